// File: dv/bcsr_top_sva.sv
// Concurrent checks of the bridge register bank at its top ports.
// Assumes one clock domain and a bind onto bcsr_top.
`timescale 1ns/1ps

module bcsr_top_sva (
    input wire logic        core_clk,               // Clock.
    input wire logic        arst_n,                 // Reset, low.
    input wire logic [7:0]  reg_addr,               // Address.
    input wire logic [7:0]  reg_wdata,              // Write data.
    input wire logic        reg_wr,                 // Write.
    input wire logic        reg_rd,                 // Read.
    input wire logic [7:0]  reg_rdata,              // Read data.
    input wire logic        source_power_input,     // Power pin.
    input wire logic        rx_irq_pending,         // Rx irq.
    input wire logic        protect_irq_pending,    // Prot irq.
    input wire logic        reload_done_pulse,      // Reload end.
    input wire logic        win_read_done,          // Window end.
    input wire logic [15:0] win_read_data,          // Window data.
    input wire logic        cec_clk,                // Gen clock.
    input wire logic        ident_sram_reload_req,  // Reload.
    input wire logic        ident_sram_clear_req,   // Clear.
    input wire logic        ident_ddc_access_block, // Block.
    input wire logic        win_read_start          // Window go.
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    logic       ctl_wr;
    logic [7:0] win_hi;
    logic [1:0] rst_cnt_q;
    logic [2:0] pwr_cnt_q;
    logic       pwr_prev_q;

    // ============
    // Helpers: control writes, age since reset, power pin age.
    assign ctl_wr = reg_wr && reg_addr == 8'h4f;
    assign win_hi = win_read_data[15:8];
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_q  <= 2'h0;
            pwr_cnt_q  <= 3'h0;
            pwr_prev_q <= 1'h0;
        end else begin
            rst_cnt_q  <= (rst_cnt_q == 2'h3) ? 2'h3 : rst_cnt_q + 2'h1;
            pwr_prev_q <= source_power_input;
            pwr_cnt_q  <= (source_power_input != pwr_prev_q) ? 3'h0 :
                          (pwr_cnt_q == 3'h7) ? 3'h7 : pwr_cnt_q + 3'h1;
        end
    end

    // ============
    // Sequences and properties.
    sequence s_win_fill;
        win_read_done && win_read_start ##2 reg_rd && reg_addr == 8'h4e;
    endsequence
    sequence s_cec_off;
        ctl_wr && !reg_wdata[3] ##1 (!ctl_wr) [*4];
    endsequence
    sequence s_irq_steady;
        ($stable(rx_irq_pending) && $stable(protect_irq_pending)) [*3]
            ##0 (rst_cnt_q == 2'h3 && reg_rd && reg_addr == 8'h50);
    endsequence
    property p_unmapped_zero;
        reg_rd && reg_addr == 8'h60 |=> reg_rdata == 8'h00;
    endproperty
    property p_reload_set;
        ctl_wr && reg_wdata[1] |=> ident_sram_reload_req;
    endproperty
    property p_reload_end;
        reload_done_pulse && !(ctl_wr && reg_wdata[1])
            |=> !ident_sram_reload_req && !ident_sram_clear_req;
    endproperty
    property p_clear_paired;
        $rose(ident_sram_clear_req) |-> ident_sram_reload_req;
    endproperty
    property p_strap_held;
        rst_cnt_q == 2'h3 |=> $stable(ident_ddc_access_block);
    endproperty
    property p_power_bit;
        rst_cnt_q == 2'h3 && pwr_cnt_q >= 3'h4 && reg_rd && reg_addr == 8'h50
            |=> reg_rdata[7] == $past(pwr_prev_q);
    endproperty
    property p_irq_bits;
        s_irq_steady |=> reg_rdata[6:5] ==
            {$past(rx_irq_pending), $past(protect_irq_pending)};
    endproperty
    property p_win_start;
        reg_wr && reg_addr == 8'h5a && reg_wdata[0] |=> win_read_start;
    endproperty
    property p_win_fill;
        s_win_fill |=> reg_rdata == $past(win_hi, 3);
    endproperty
    property p_cec_off;
        s_cec_off |-> !cec_clk;
    endproperty

    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");
    a_reload_set: assert property (p_reload_set)
        else $error("reload request not raised");
    a_reload_end: assert property (p_reload_end)
        else $error("requests not cleared after reload");
    a_clear_paired: assert property (p_clear_paired)
        else $error("clear raised without reload");
    a_strap_held: assert property (p_strap_held)
        else $error("access block changed after capture");
    a_power_bit: assert property (p_power_bit)
        else $error("power status bit wrong");
    a_irq_bits: assert property (p_irq_bits)
        else $error("pending irq status bits wrong");
    a_win_start: assert property (p_win_start)
        else $error("window read not started");
    a_win_fill: assert property (p_win_fill)
        else $error("window byte not loaded");
    a_cec_off: assert property (p_cec_off)
        else $error("control clock runs while disabled");
endmodule // bcsr_top_sva

bind bcsr_top bcsr_top_sva i_bcsr_top_sva (.*);

// File: dv/bcsr_top_tb_top.sv
// Self-checking bench of the bridge register bank with a byte model.
// Assumes bcsr_top and its bound checker are compiled before it.
`timescale 1ns/1ps

module bcsr_top_tb_top;
    logic        clk, rst_n, wr_s, rd_s, pwr, strap, rx, prot, tick, cec;
    logic        pass, rl, cl, blk, wst, irq_n;
    logic [7:0]  addr, wdat, rdat, rd_v;
    logic [6:0]  ev;
    logic [15:0] wdata16;
    logic [31:0] rng;
    int          n_mismatch, cmp_count, cyc, cnt, exp_e;
    int          m_q[$];

    // ============
    // Clock and device.
    initial clk = 1'h0;
    always #20 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    bcsr_top i_bcsr_top (.core_clk(clk), .arst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wdat), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat),
        .source_power_input(pwr), .mode_strap_pin0(strap),
        .rx_irq_pending(rx), .protect_irq_pending(prot),
        .cfg_done_pulse(ev[0]), .init_done_pulse(ev[1]),
        .remote_load_pulse(ev[2]), .config_checksum_ok_valid(ev[3]),
        .config_checksum_ok_pass(pass), .ident_cksum_valid(ev[4]),
        .ident_cksum_pass(pass), .reload_done_pulse(ev[5]),
        .win_read_done(ev[6]), .win_read_data(wdata16),
        .int_ref_tick(tick), .cec_clk(cec), .ident_sram_reload_req(rl),
        .ident_sram_clear_req(cl), .ident_ddc_access_block(blk),
        .win_read_start(wst), .interrupt_out_n(irq_n));

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ============
    // Tasks.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input string nm, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        wr_s <= 1'h1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr_s <= 1'h0;
        #1;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, e);
        @(posedge clk);
        rd_s <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'h0;
        #1 rd_v = rdat;
        chk(nm, rd_v, e);
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 7'h0;
        #1;
    endtask
    task automatic edges(input int n, input int per);
        logic prev;
        prev = cec;
        cnt = 0;
        exp_e = (n / per) * 32768 / 25000000;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (cec && !prev) cnt++;
            prev = cec;
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ============
    // Main sequence.
    initial begin
        {rst_n, wr_s, rd_s, pwr, rx, prot, tick, pass} = 8'h0;
        {addr, wdat, ev, wdata16, cyc, n_mismatch, cmp_count} = '0;
        strap = 1'h1;
        rng = 32'h4e0b;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        rchk("byte2", 8'h4d, 8'h00);
        rchk("byte3", 8'h4e, 8'h00);
        rchk("status", 8'h50, 8'h03);
        rchk("control", 8'h4f, 8'h01);
        chk("block pin", {7'h0, blk}, 8'h01);
        @(posedge clk) strap <= 1'h0;
        wr(8'h50, 8'hff);
        rchk("status ro", 8'h50, 8'h03);
        wr(8'h60, 8'hff);
        rchk("unmapped", 8'h60, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            m_q.push_back(rng[7:0]);
            m_q.push_back(rng[15:8]);
            wr(8'h4d, rng[7:0]);
            wr(8'h4e, rng[15:8]);
            rchk("byte2", 8'h4d, 8'(m_q.pop_front()));
            rchk("byte3", 8'h4e, 8'(m_q.pop_front()));
        end
        $display("test reset and data done");
        wr(8'h4f, 8'h04);
        chk("clear alone", {7'h0, cl}, 8'h00);
        wr(8'h4f, 8'hff);
        chk("requests", {6'h0, cl, rl}, 8'h03);
        rchk("control", 8'h4f, 8'h1f);
        pulse(7'h20);
        chk("requests end", {6'h0, cl, rl}, 8'h00);
        rchk("control", 8'h4f, 8'h19);
        edges(6000, 1);
        chk("cec ext", {7'h0, cnt >= exp_e && cnt <= exp_e + 1}, 8'h01);
        wr(8'h4f, 8'h08);
        edges(6000, 2);
        chk("cec int", {7'h0, cnt >= exp_e && cnt <= exp_e + 1}, 8'h01);
        wr(8'h4f, 8'h00);
        edges(3000, 1);
        chk("cec off", cnt[7:0], 8'h00);
        $display("test control done");
        @(posedge clk);
        pwr <= 1'h1;
        rx <= 1'h1;
        pulse(7'h01);
        pulse(7'h02);
        pulse(7'h04);
        pulse(7'h18);
        rchk("status", 8'h50, 8'hdc);
        rchk("irq status", 8'h58, 8'h5f);
        chk("pin idle", {7'h0, irq_n}, 8'h01);
        wr(8'h59, 8'h10);
        @(posedge clk);
        #1 chk("pin rx", {7'h0, irq_n}, 8'h00);
        wr(8'h58, 8'h10);
        @(posedge clk);
        #1 chk("pin cleared", {7'h0, irq_n}, 8'h01);
        rchk("irq status", 8'h58, 8'h4f);
        @(posedge clk);
        prot <= 1'h1;
        pass <= 1'h1;
        wr(8'h59, 8'h20);
        pulse(7'h08);
        chk("pin prot", {7'h0, irq_n}, 8'h00);
        rchk("status", 8'h50, 8'hfe);
        $display("test status done");
        rng = xs(rng);
        @(posedge clk) wdata16 <= rng[15:0];
        wr(8'h5a, 8'h01);
        chk("win start", {7'h0, wst}, 8'h01);
        pulse(7'h40);
        chk("win end", {7'h0, wst}, 8'h00);
        rchk("byte3", 8'h4e, rng[15:8]);
        rchk("byte2", 8'h4d, rng[7:0]);
        $display("test window done");
        end_of_test();
    end
endmodule // bcsr_top_tb_top

// File: rtl/bcsr_cec_gen.sv
// Generates the 32.768 kHz control clock by a phase accumulator.
// Assumes core_clk is the 25 MHz external oscillator and int_ref_tick is a
// one-cycle pulse from on-chip logic at the internal reference rate.
`timescale 1ns/1ps
`include "bcsr_params.svh"

module bcsr_cec_gen #(
    parameter int ACC_W = `BCSR_ACC_W
) (
    input  wire logic core_clk,     // Core clock, 25 MHz.
    input  wire logic arst_n,       // Asynchronous reset, active low.
    input  wire logic int_ref_tick, // Internal reference tick.
    bcsr_cec_if.gen   cec           // Control and clock output.
);
    import bcsr_pkg::*;

    // ======================================================================
    // Increment per reference edge
    function automatic logic [ACC_W-1:0] bcsr_inc(input longint ref_hz);
        longint num;
        num = longint'(`BCSR_CEC_HZ) << ACC_W;
        return ACC_W'(num / ref_hz);
    endfunction

    localparam logic [ACC_W-1:0] INC_EXT = bcsr_inc(`BCSR_EXT_OSC_HZ);
    localparam logic [ACC_W-1:0] INC_INT = bcsr_inc(`BCSR_INT_REF_HZ);

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             clk_out;
    } bcsr_gen_s;

    bcsr_gen_s st_q;
    bcsr_gen_s st_d;

    // ======================================================================
    // Next state
    // Accumulates on the selected reference; held at zero when disabled.
    always_comb begin
        st_d = st_q;
        if (!cec.enable) begin
            st_d.acc = '0;
        end else if (cec.source == BCSR_CEC_SRC_EXTERNAL) begin
            st_d.acc = st_q.acc + INC_EXT;
        end else if (int_ref_tick) begin
            st_d.acc = st_q.acc + INC_INT;
        end
        st_d.clk_out = st_d.acc[ACC_W-1];
    end

    // Registers the state.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cec.cec_clk = st_q.clk_out;

endmodule // bcsr_cec_gen

// File: rtl/bcsr_top.sv
// Holds the bridge control and status register bank with its interrupt.
// Assumes a simple register port on core_clk, pins for power detect and the
// mode strap, and event pulses from the initialisation engine on core_clk.
//
// Summary of operation
// - Bytes 2 and 3 stored, reset zero.
// - Control bit 4 picks control clock source.
// - Control bit 3 enables control clock generation.
// - Clear needs reload written together; self-clears.
// - Control bit 1 starts reload; self-clears.
// - Bit 0 blocks channel access, strap-captured.
// - Status bit 7 shows source power.
// - Status bit 6 shows receiver interrupt pending.
// - Status bit 5 shows protection interrupt pending.
// - Bits 2 then 4 mark configuration, initialisation.
// - Status bit 3 marks remote identification load.
// - Status bit 1 holds configuration checksum result.
// - Status bit 0 holds identification checksum result.
// - Read start loads window bytes, self-clears.
// - Any enabled interrupt status bit drives interrupt pin.
`timescale 1ns/1ps
`include "bcsr_params.svh"

module bcsr_top (
    input  wire logic         core_clk,              // Core clock, 25 MHz.
    input  wire logic         arst_n,                // Async reset, low.
    input  wire logic [7:0]   reg_addr,              // Register address.
    input  wire logic [7:0]   reg_wdata,             // Write data.
    input  wire logic         reg_wr,                // Write strobe.
    input  wire logic         reg_rd,                // Read strobe.
    output logic [7:0]        reg_rdata,             // Read data, next cycle.
    input  wire logic         source_power_input,    // Source power pin.
    input  wire logic         mode_strap_pin0,       // Mode strap pin.
    input  wire logic         rx_irq_pending,        // Receiver irq level.
    input  wire logic         protect_irq_pending,   // Protection irq level.
    input  wire logic         cfg_done_pulse,        // Configuration done.
    input  wire logic         init_done_pulse,       // Initialisation done.
    input  wire logic         remote_load_pulse,     // Remote load done.
    input  wire logic         config_checksum_ok_valid,       // Config result strobe.
    input  wire logic         config_checksum_ok_pass,        // Config result.
    input  wire logic         ident_cksum_valid,     // Ident result strobe.
    input  wire logic         ident_cksum_pass,      // Ident result.
    input  wire logic         reload_done_pulse,     // Reload finished.
    input  wire logic         win_read_done,         // Window read finished.
    input  wire logic [15:0]  win_read_data,         // Window bytes 3:2.
    input  wire logic         int_ref_tick,          // Internal clock tick.
    output logic              cec_clk,               // Control clock out.
    output logic              ident_sram_reload_req, // Reload request.
    output logic              ident_sram_clear_req,  // Clear request.
    output logic              ident_ddc_access_block,// Channel access block.
    output logic              win_read_start,        // Window read request.
    output logic              interrupt_out_n        // Interrupt, low.
);
    import bcsr_pkg::*;

    // ======================================================================
    // State
    typedef struct packed {
        logic       pwr_s1;
        logic       pwr_s2;
        logic       pwr_prev;
        logic       strap_s1;
        logic       strap_s2;
        logic [1:0] strap_taken;
        logic       rx_prev;
        logic       prot_prev;
        bcsr_byte_t data2;
        bcsr_byte_t data3;
        logic       cec_src;
        logic       cec_en;
        logic       clear_bit;
        logic       reload_bit;
        logic       ddc_block;
        bcsr_byte_t status;
        bcsr_byte_t irq_sts;
        bcsr_byte_t irq_mask;
        logic       read_start;
        bcsr_byte_t rdata;
        logic       irq_n;
        logic       cec_clk;
    } bcsr_state_s;

    bcsr_state_s st_q;
    bcsr_state_s st_d;

    // Reset image of the state.
    localparam bcsr_state_s RST_STATE = '{
        pwr_s1:      1'b0,
        pwr_s2:      1'b0,
        pwr_prev:    1'b0,
        strap_s1:    1'b0,
        strap_s2:    1'b0,
        strap_taken: 2'h0,
        rx_prev:     1'b0,
        prot_prev:   1'b0,
        data2:       `BCSR_RST_DATA,
        data3:       `BCSR_RST_DATA,
        cec_src:     1'b0,
        cec_en:      1'b0,
        clear_bit:   1'b0,
        reload_bit:  1'b0,
        ddc_block:   1'b0,
        status:      `BCSR_RST_STATUS,
        irq_sts:     8'h00,
        irq_mask:    `BCSR_RST_IRQ_MASK,
        read_start:  1'b0,
        rdata:       8'h00,
        irq_n:       1'b1,
        cec_clk:     1'b0
    };

    // ======================================================================
    // Address decode
    function automatic logic bcsr_hit(input bcsr_addr_t a,
                                      input bcsr_addr_t ofs);
        return a == ofs;
    endfunction

    logic wr_data2;
    logic wr_data3;
    logic wr_ctl;
    logic wr_irq_sts;
    logic wr_irq_mask;
    logic wr_win;

    // Qualifies each register write by its offset.
    assign wr_data2    = reg_wr && bcsr_hit(reg_addr, `BCSR_OFS_DATA_BYTE2);
    assign wr_data3    = reg_wr && bcsr_hit(reg_addr, `BCSR_OFS_DATA_BYTE3);
    assign wr_ctl      = reg_wr && bcsr_hit(reg_addr, `BCSR_OFS_CONTROL);
    assign wr_irq_sts  = reg_wr && bcsr_hit(reg_addr, `BCSR_OFS_IRQ_STATUS);
    assign wr_irq_mask = reg_wr && bcsr_hit(reg_addr, `BCSR_OFS_IRQ_MASK);
    assign wr_win      = reg_wr && bcsr_hit(reg_addr, `BCSR_OFS_WINDOW_CTL);

    // ======================================================================
    // Control clock generator
    bcsr_cec_if cec_if ();

    // Drives the generator from the control register.
    assign cec_if.enable = st_q.cec_en;
    assign cec_if.source = bcsr_cec_src_e'(st_q.cec_src);

    bcsr_cec_gen u_cec_gen (
        .core_clk     (core_clk),
        .arst_n       (arst_n),
        .int_ref_tick (int_ref_tick),
        .cec          (cec_if.gen)
    );

    // ======================================================================
    // Register views
    logic [7:0] ctl_view;
    logic [7:0] win_view;
    logic [7:0] irq_evt;

    // Composes the control and window views; reserved bits stay zero.
    always_comb begin
        ctl_view = 8'h00;
        ctl_view[`BCSR_CTL_CEC_SRC]   = st_q.cec_src;
        ctl_view[`BCSR_CTL_CEC_EN]    = st_q.cec_en;
        ctl_view[`BCSR_CTL_CLEAR]     = st_q.clear_bit;
        ctl_view[`BCSR_CTL_RELOAD]    = st_q.reload_bit;
        ctl_view[`BCSR_CTL_DDC_BLOCK] = st_q.ddc_block;
        win_view = 8'h00;
        win_view[`BCSR_WIN_READ_START] = st_q.read_start;
    end

    // Collects the one-cycle events that set interrupt status bits.
    always_comb begin
        irq_evt = 8'h00;
        irq_evt[`BCSR_IRQ_INIT_DONE]   = init_done_pulse;
        irq_evt[`BCSR_IRQ_CFG_DONE]    = cfg_done_pulse;
        irq_evt[`BCSR_IRQ_REMOTE_LOAD] = remote_load_pulse;
        irq_evt[`BCSR_IRQ_CKSUM]       = config_checksum_ok_valid
                                       | ident_cksum_valid;
        irq_evt[`BCSR_IRQ_RX]          = rx_irq_pending & ~st_q.rx_prev;
        irq_evt[`BCSR_IRQ_PROT]        = protect_irq_pending
                                       & ~st_q.prot_prev;
        irq_evt[`BCSR_IRQ_POWER]       = st_q.pwr_s2 ^ st_q.pwr_prev;
    end

    // ======================================================================
    // Next state
    always_comb begin
        st_d = st_q;

        // Two flip-flops on the power and strap pins before any logic reads them.
        st_d.pwr_s1   = source_power_input;
        st_d.pwr_s2   = st_q.pwr_s1;
        st_d.pwr_prev = st_q.pwr_s2;
        st_d.strap_s1 = mode_strap_pin0;
        st_d.strap_s2 = st_q.strap_s1;
        st_d.rx_prev  = rx_irq_pending;
        st_d.prot_prev = protect_irq_pending;

        // Strap captured once, after the synchroniser fills.
        if (st_q.strap_taken != 2'h3) begin
            st_d.strap_taken = st_q.strap_taken + 2'h1;
        end
        if (st_q.strap_taken == 2'h2) begin
            st_d.ddc_block = st_q.strap_s2;
        end

        if (wr_data2) begin
            st_d.data2 = reg_wdata;
        end
        if (wr_data3) begin
            st_d.data3 = reg_wdata;
        end

        if (win_read_done) begin
            st_d.data2 = win_read_data[7:0];
            st_d.data3 = win_read_data[15:8];
            st_d.read_start = 1'b0;
        end
        if (wr_win && reg_wdata[`BCSR_WIN_READ_START]) begin
            st_d.read_start = 1'b1;
        end

        if (reload_done_pulse) begin
            st_d.reload_bit = 1'b0;
            st_d.clear_bit  = 1'b0;
        end

        // Control writes; bit 0 and reserved bits are not writable.
        if (wr_ctl) begin
            st_d.cec_src    = reg_wdata[`BCSR_CTL_CEC_SRC];
            st_d.cec_en     = reg_wdata[`BCSR_CTL_CEC_EN];
            st_d.reload_bit = reg_wdata[`BCSR_CTL_RELOAD]
                            | st_d.reload_bit;
            st_d.clear_bit  = (reg_wdata[`BCSR_CTL_CLEAR]
                            & reg_wdata[`BCSR_CTL_RELOAD])
                            | st_d.clear_bit;
        end

        st_d.status[`BCSR_STS_POWER]     = st_q.pwr_s2;
        st_d.status[`BCSR_STS_RX_IRQ]    = rx_irq_pending;
        st_d.status[`BCSR_STS_PROT_IRQ]  = protect_irq_pending;

        if (cfg_done_pulse) begin
            st_d.status[`BCSR_STS_CFG_DONE] = 1'b1;
        end
        if (init_done_pulse) begin
            st_d.status[`BCSR_STS_INIT_DONE] = 1'b1;
        end
        if (remote_load_pulse) begin
            st_d.status[`BCSR_STS_REMOTE_LOAD] = 1'b1;
        end
        if (config_checksum_ok_valid) begin
            st_d.status[`BCSR_STS_CONFIG_CHECKSUM_OK] = config_checksum_ok_pass;
        end
        if (ident_cksum_valid) begin
            st_d.status[`BCSR_STS_IDENT_CKSUM] = ident_cksum_pass;
        end

        // Interrupt status: write one clears, a new event wins.
        if (wr_irq_sts) begin
            st_d.irq_sts = st_q.irq_sts & ~reg_wdata;
        end
        st_d.irq_sts = (st_d.irq_sts | irq_evt) & `BCSR_IRQ_USED;
        if (wr_irq_mask) begin
            st_d.irq_mask = reg_wdata & `BCSR_IRQ_USED;
        end

        st_d.irq_n = ~|(st_d.irq_sts & st_d.irq_mask);

        st_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `BCSR_OFS_DATA_BYTE2: st_d.rdata = st_q.data2;
                `BCSR_OFS_DATA_BYTE3: st_d.rdata = st_q.data3;
                `BCSR_OFS_CONTROL:    st_d.rdata = ctl_view;
                `BCSR_OFS_STATUS:     st_d.rdata = st_q.status;
                `BCSR_OFS_IRQ_STATUS: st_d.rdata = st_q.irq_sts;
                `BCSR_OFS_IRQ_MASK:   st_d.rdata = st_q.irq_mask;
                `BCSR_OFS_WINDOW_CTL: st_d.rdata = win_view;
                default:              st_d.rdata = 8'h00;
            endcase
        end

        // Retimes the generated clock so the output leaves a flop.
        st_d.cec_clk = cec_if.cec_clk;
    end

    // ======================================================================
    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= RST_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // Outputs, all straight from flops
    assign reg_rdata              = st_q.rdata;
    assign cec_clk                = st_q.cec_clk;
    assign ident_sram_reload_req  = st_q.reload_bit;
    assign ident_sram_clear_req   = st_q.clear_bit;
    assign ident_ddc_access_block = st_q.ddc_block;
    assign win_read_start         = st_q.read_start;
    assign interrupt_out_n        = st_q.irq_n;

endmodule // bcsr_top

// File: shared/bcsr_cec_if.sv
// Carries the control and output of the control clock generator.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps

interface bcsr_cec_if;
    import bcsr_pkg::*;

    logic          enable;   // Generation enable.
    bcsr_cec_src_e source;   // Reference source.
    logic          cec_clk;  // Generated clock.

    modport ctrl (output enable, output source, input cec_clk);
    modport gen  (input enable, input source, output cec_clk);
endinterface

// File: shared/bcsr_params.svh
// Holds the register map, field positions, reset values and clock figures
// of the bridge control and status register bank.
// Assumes it is included by bare name from the package and the modules.
`ifndef BCSR_PARAMS_SVH
`define BCSR_PARAMS_SVH

// ==========================================================================
// Register offsets
`define BCSR_OFS_DATA_BYTE2   8'h4d
`define BCSR_OFS_DATA_BYTE3   8'h4e
`define BCSR_OFS_CONTROL      8'h4f
`define BCSR_OFS_STATUS       8'h50
`define BCSR_OFS_IRQ_STATUS   8'h58
`define BCSR_OFS_IRQ_MASK     8'h59
`define BCSR_OFS_WINDOW_CTL   8'h5a

// ==========================================================================
// Control register fields
`define BCSR_CTL_CEC_SRC      4
`define BCSR_CTL_CEC_EN       3
`define BCSR_CTL_CLEAR        2
`define BCSR_CTL_RELOAD       1
`define BCSR_CTL_DDC_BLOCK    0

// ==========================================================================
// Status register fields
`define BCSR_STS_POWER        7
`define BCSR_STS_RX_IRQ       6
`define BCSR_STS_PROT_IRQ     5
`define BCSR_STS_INIT_DONE    4
`define BCSR_STS_REMOTE_LOAD  3
`define BCSR_STS_CFG_DONE     2
`define BCSR_STS_CONFIG_CHECKSUM_OK    1
`define BCSR_STS_IDENT_CKSUM  0

// ==========================================================================
// Interrupt status and mask fields
`define BCSR_IRQ_INIT_DONE    0
`define BCSR_IRQ_CFG_DONE     1
`define BCSR_IRQ_REMOTE_LOAD  2
`define BCSR_IRQ_CKSUM        3
`define BCSR_IRQ_RX           4
`define BCSR_IRQ_PROT         5
`define BCSR_IRQ_POWER        6
`define BCSR_IRQ_USED         8'h7f

// ==========================================================================
// Window control fields
`define BCSR_WIN_READ_START   0

// ==========================================================================
// Reset values
`define BCSR_RST_DATA         8'h00
`define BCSR_RST_STATUS       8'h03
`define BCSR_RST_IRQ_MASK     8'h00

// ==========================================================================
// Clock figures
`define BCSR_CEC_HZ           32768
`define BCSR_EXT_OSC_HZ       25000000
`define BCSR_INT_REF_HZ       25000000
`define BCSR_ACC_W            24

`endif

// File: shared/bcsr_pkg.sv
// Holds the types shared by the bridge control and status register bank.
// Assumes bcsr_params.svh is on the include path.
`include "bcsr_params.svh"

package bcsr_pkg;

    // ======================================================================
    // Common types
    typedef logic [7:0] bcsr_byte_t;
    typedef logic [7:0] bcsr_addr_t;

    // Source selection of the consumer electronics control clock.
    typedef enum logic {
        BCSR_CEC_SRC_INTERNAL,
        BCSR_CEC_SRC_EXTERNAL
    } bcsr_cec_src_e;

endpackage
